/* verilog/interval_timer.v */
// Bus programming and readback of a three-counter interval timer
`timescale 1ns/1ns
`default_nettype none
`include "timer_defines.vh"

module interval_timer #(
    parameter CHANNELS = 3,
    parameter COUNT_WIDTH = 16
) (
    input wire clock,
    input wire rst_n,
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire port_sel_hi,
    input wire port_sel_lo,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe_n,
    input wire [CHANNELS-1:0] counter_clk,
    input wire [CHANNELS-1:0] gate,
    input wire [CHANNELS-1:0] out_level,
    output reg [CHANNELS-1:0] count_load,
    output wire [CHANNELS*`CW_KEPT_WIDTH-1:0] mode_word,
    output wire [CHANNELS*COUNT_WIDTH-1:0] down_count
);

    // ============================================================
    // Bus strobe qualification
    wire [1:0] port_sel;
    wire wr_act;
    wire rd_act;
    wire wr_ev;
    wire rd_end;
    wire cw_wr;
    wire rb_cmd;
    wire [1:0] cw_select;
    wire [1:0] cw_access;
    reg wr_act_q;
    reg rd_act_q;
    reg [1:0] rd_port_q;
    wire [CHANNELS*8-1:0] rd_bytes;
    reg [7:0] data_out_d;

    assign port_sel = {port_sel_hi, port_sel_lo};
    // Chip select gates both strobes; a write wins if both are low
    assign wr_act = ~cs_n & ~wr_n;
    assign rd_act = ~cs_n & ~rd_n & wr_n;
    // A write is taken once, on the first cycle the strobe is seen
    assign wr_ev = wr_act & ~wr_act_q;
    // A read is consumed when the strobe ends, so the byte stays
    // steady on the bus for the whole strobe
    assign rd_end = rd_act_q & ~rd_act;
    assign cw_wr = wr_ev & (port_sel == `MODE_COMMAND_PORT);
    assign cw_select = data_in[`CW_SELECT_MSB:`CW_SELECT_LSB];
    assign cw_access = data_in[`CW_ACCESS_MSB:`CW_ACCESS_LSB];
    assign rb_cmd = cw_wr & (cw_select == `SELECT_READBACK);

    // Strobe history and the port of the read in progress
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            rd_port_q <= 2'h0;
        end else begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
            if (rd_act) begin
                rd_port_q <= port_sel;
            end
        end
    end

    // ============================================================
    // Per-counter programming, latching and byte sequencing
    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : chan
            reg [`CW_KEPT_WIDTH-1:0] ctrl_q;
            reg [COUNT_WIDTH-1:0] count_reg_q;
            reg wr_hi_q;
            reg rd_hi_q;
            reg load_req_q;
            reg null_q;
            reg cnt_held_q;
            reg [COUNT_WIDTH-1:0] cnt_latch_q;
            reg sts_held_q;
            reg [7:0] sts_latch_q;
            reg cclk_q;
            wire [1:0] access;
            wire sel_me;
            wire prog;
            wire latch_cmd;
            wire rb_sel;
            wire cnt_lat_req;
            wire sts_lat_req;
            wire data_wr;
            wire write_done;
            wire rd_done;
            wire step_en;
            wire load_now;
            wire [COUNT_WIDTH-1:0] cnt_live;
            wire [COUNT_WIDTH-1:0] cnt_src;
            reg [7:0] rbyte;
            // Two-bit channel number, so no bit-select of the genvar
            localparam [1:0] CHAN_ID = i;

            assign access = ctrl_q[`CW_ACCESS_MSB:`CW_ACCESS_LSB];
            assign sel_me = (cw_select == CHAN_ID);
            // Any counter may be set up at any time, none first
            assign prog = cw_wr & sel_me & (cw_access != `ACCESS_LATCH);
            assign latch_cmd = cw_wr & sel_me
                & (cw_access == `ACCESS_LATCH);
            assign rb_sel = rb_cmd & data_in[`RB_MASK_LSB + i];
            // Latch command and read-back count request behave alike
            assign cnt_lat_req = latch_cmd
                | (rb_sel & ~data_in[`RB_COUNT_N_BIT]);
            assign sts_lat_req = rb_sel
                & ~data_in[`RB_STATUS_N_BIT];
            assign data_wr = wr_ev & (port_sel == CHAN_ID);
            // A count is complete on the single byte, or on the
            // second byte of the two-byte format
            assign write_done = data_wr
                & ((access != `ACCESS_LOW_HIGH) | wr_hi_q);
            assign rd_done = rd_end & (rd_port_q == CHAN_ID);
            // Counter clock pulse ends on the falling edge of its clock
            assign step_en = cclk_q & ~counter_clk[i];
            assign load_now = step_en & load_req_q;
            // Live source for a direct read is the running counter
            assign cnt_src = cnt_held_q ? cnt_latch_q : cnt_live;

            down_counter #(
                .WIDTH(COUNT_WIDTH)
            ) u_down (
                .clock(clock),
                .rst_n(rst_n),
                .step_en(step_en),
                .load(load_req_q),
                .load_value(count_reg_q),
                .bcd(ctrl_q[`CW_BCD_BIT]),
                .count_en(gate[i]),
                .count_q(cnt_live)
            );

            // Byte offered on a read of this counter
            always @* begin
                rbyte = cnt_src[7:0];
                if (sts_held_q) begin
                    rbyte = sts_latch_q;
                end else if (access == `ACCESS_HIGH) begin
                    rbyte = cnt_src[15:8];
                end else if (access == `ACCESS_LOW_HIGH && rd_hi_q) begin
                    rbyte = cnt_src[15:8];
                end
            end

            // Counter clock history for the edge detect
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    cclk_q <= 1'b0;
                end else begin
                    cclk_q <= counter_clk[i];
                end
            end

            // Mode byte, count register and write byte pointer
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_q <= `CTRL_RESET;
                    count_reg_q <= `COUNT_RESET;
                    wr_hi_q <= 1'b0;
                end else if (prog) begin
                    // Kept bits feed the status byte until the next
                    // mode byte for this counter
                    ctrl_q <= data_in[`CW_KEPT_WIDTH-1:0];
                    wr_hi_q <= 1'b0;
                end else if (data_wr) begin
                    case (access)
                        `ACCESS_LOW: begin
                            count_reg_q <= {8'h00, data_in};
                        end
                        `ACCESS_HIGH: begin
                            count_reg_q <= {data_in, 8'h00};
                        end
                        `ACCESS_LOW_HIGH: begin
                            // Low byte first, then high byte
                            if (wr_hi_q) begin
                                count_reg_q[15:8] <= data_in;
                            end else begin
                                count_reg_q[7:0] <= data_in;
                            end
                            wr_hi_q <= ~wr_hi_q;
                        end
                        default: begin
                            count_reg_q <= count_reg_q;
                        end
                    endcase
                end
            end

            // Pending load and null count flag
            // A completed write in the load cycle wins over the clear,
            // so the new count is not lost
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    load_req_q <= 1'b0;
                    null_q <= 1'b0;
                end else if (prog) begin
                    load_req_q <= 1'b0;
                    null_q <= 1'b1;
                end else if (write_done) begin
                    load_req_q <= 1'b1;
                    null_q <= 1'b1;
                end else if (load_now) begin
                    load_req_q <= 1'b0;
                    null_q <= 1'b0;
                end
            end

            // Count latch: captured once, held until fully read
            // The latch is a copy, so the counter itself runs on
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_held_q <= 1'b0;
                    cnt_latch_q <= `COUNT_RESET;
                end else if (prog) begin
                    cnt_held_q <= 1'b0;
                end else if (cnt_lat_req && !cnt_held_q) begin
                    cnt_held_q <= 1'b1;
                    cnt_latch_q <= cnt_live;
                end else if (rd_done && !sts_held_q && cnt_held_q) begin
                    // Only this counter's reads release its latch
                    if (access != `ACCESS_LOW_HIGH || rd_hi_q) begin
                        cnt_held_q <= 1'b0;
                    end
                end
                // A repeat request while held falls through
            end

            // Status latch: first request wins, released by one read
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    sts_held_q <= 1'b0;
                    sts_latch_q <= `DATA_RESET;
                end else if (prog) begin
                    sts_held_q <= 1'b0;
                end else if (sts_lat_req && !sts_held_q) begin
                    sts_held_q <= 1'b1;
                    sts_latch_q <= {out_level[i], null_q, ctrl_q};
                end else if (rd_done && sts_held_q) begin
                    // Status goes first; the count stays for later
                    sts_held_q <= 1'b0;
                end
            end

            // Read byte pointer, independent of the write pointer
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    rd_hi_q <= 1'b0;
                end else if (prog) begin
                    rd_hi_q <= 1'b0;
                end else if (rd_done && !sts_held_q
                    && access == `ACCESS_LOW_HIGH) begin
                    rd_hi_q <= ~rd_hi_q;
                end
            end

            // Load event pulse toward the waveform logic
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    count_load[i] <= 1'b0;
                end else begin
                    count_load[i] <= load_now;
                end
            end

            assign rd_bytes[8*i +: 8] = rbyte;
            assign mode_word[`CW_KEPT_WIDTH*i +: `CW_KEPT_WIDTH] = ctrl_q;
            assign down_count[COUNT_WIDTH*i +: COUNT_WIDTH] = cnt_live;
        end
    endgenerate

    // ============================================================
    // Read data path
    // Command port reads and idle bus leave the pins released
    always @* begin
        data_out_d = `DATA_RESET;
        case (port_sel)
            `COUNTER0_DATA_PORT: begin
                data_out_d = rd_bytes[7:0];
            end
            `COUNTER1_DATA_PORT: begin
                data_out_d = rd_bytes[15:8];
            end
            `COUNTER2_DATA_PORT: begin
                data_out_d = rd_bytes[23:16];
            end
            default: begin
                data_out_d = `DATA_RESET;
            end
        endcase
    end

    // Registered drive: one cycle behind the strobe, a trade for
    // clean flop outputs on the pins
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= `DATA_RESET;
            data_oe_n <= 1'b1;
        end else begin
            data_out <= data_out_d;
            data_oe_n <= ~(rd_act
                & (port_sel != `MODE_COMMAND_PORT));
        end
    end

endmodule

`default_nettype wire

/* verilog/timer_defines.vh */
// Constants shared by the interval timer bus and counter logic
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// ============================================================
// Port offsets selected by the two address lines
`define COUNTER0_DATA_PORT 2'h0
`define COUNTER1_DATA_PORT 2'h1
`define COUNTER2_DATA_PORT 2'h2
`define MODE_COMMAND_PORT 2'h3

// ============================================================
// Mode command byte fields
`define CW_BCD_BIT 0
`define CW_MODE_LSB 1
`define CW_MODE_MSB 3
`define CW_ACCESS_LSB 4
`define CW_ACCESS_MSB 5
`define CW_SELECT_LSB 6
`define CW_SELECT_MSB 7
`define CW_KEPT_WIDTH 6

// Byte access codes
`define ACCESS_LATCH 2'h0
`define ACCESS_LOW 2'h1
`define ACCESS_HIGH 2'h2
`define ACCESS_LOW_HIGH 2'h3

// Counter select code that turns the byte into a read-back command
`define SELECT_READBACK 2'h3

// Read-back command bits (count and status are active low)
`define RB_MASK_LSB 1
`define RB_STATUS_N_BIT 4
`define RB_COUNT_N_BIT 5

// ============================================================
// Counter state byte fields
`define STS_OUT_BIT 7
`define STS_NULL_BIT 6

// Reset values
`define CTRL_RESET 6'h00
`define COUNT_RESET 16'h0000
`define DATA_RESET 8'h00

`endif

/* verilog/down_counter.v */
// Down-counter of one timer channel, binary or four-decade BCD
`timescale 1ns/1ns
`default_nettype none

module down_counter #(
    parameter WIDTH = 16
) (
    input wire clock,
    input wire rst_n,
    input wire step_en,
    input wire load,
    input wire [WIDTH-1:0] load_value,
    input wire bcd,
    input wire count_en,
    output reg [WIDTH-1:0] count_q
);

    reg [WIDTH-1:0] dec_d;
    reg borrow;
    integer n;

    // ============================================================
    // Next value after one decrement
    // In BCD each nibble wraps 0 to 9, so 0000 rolls to 9999
    always @* begin
        dec_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
        borrow = 1'b1;
        if (bcd) begin
            for (n = 0; n < WIDTH / 4; n = n + 1) begin
                if (borrow) begin
                    if (count_q[4*n +: 4] == 4'h0) begin
                        dec_d[4*n +: 4] = 4'h9;
                    end else begin
                        dec_d[4*n +: 4] = count_q[4*n +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end else begin
                    dec_d[4*n +: 4] = count_q[4*n +: 4];
                end
            end
        end
    end

    // ============================================================
    // Load has priority over counting on the same clock pulse
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= {WIDTH{1'b0}};
        end else if (step_en) begin
            if (load) begin
                count_q <= load_value;
            end else if (count_en) begin
                count_q <= dec_d;
            end
        end
    end

endmodule

`default_nettype wire

/* tb/host_bus_model.sv */
// Host processor model driving the timer strobes, address and data
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
    input wire logic clock,
    output var logic cs_n,
    output var logic rd_n,
    output var logic wr_n,
    output var logic port_sel_hi,
    output var logic port_sel_lo,
    output wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n
);
    logic [7:0] drv_q = 8'h00;
    logic drv_en = 1'b0;
    // ==========================================
    // Bus wire
    // Undriven bus shows the inverse of the last host byte, never a kept value
    assign data_in = !data_oe_n ? data_out : (drv_en ? drv_q : ~drv_q);
    initial begin
        {cs_n, rd_n, wr_n} = 3'h7;
        {port_sel_hi, port_sel_lo} = 2'h0;
    end
    // Write: strobe held two edges, released on a falling edge
    task wr(input logic [1:0] p, input logic [7:0] d);
        @(negedge clock);
        {port_sel_hi, port_sel_lo} = p;
        drv_q = d;
        drv_en = 1'b1;
        {cs_n, wr_n} = 2'h0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        {cs_n, wr_n} = 2'h3;
        drv_en = 1'b0;
    endtask
    // Read: data taken at the third edge, before the strobe is dropped
    task rd(input logic [1:0] p, output logic [7:0] d);
        @(negedge clock);
        {port_sel_hi, port_sel_lo} = p;
        {cs_n, rd_n} = 2'h0;
        repeat (3) @(posedge clock);
        d = data_out;
        @(negedge clock);
        {cs_n, rd_n} = 2'h3;
    endtask
endmodule
`default_nettype wire

/* tb/timer_properties.sv */
// Port-level assertions for the interval timer bus and load logic
`timescale 1ns/1ns
`default_nettype none
`include "timer_defines.vh"
module timer_properties #(
    parameter CHANNELS = 3,
    parameter COUNT_WIDTH = 16
) (
    input wire clock,
    input wire rst_n,
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire port_sel_hi,
    input wire port_sel_lo,
    input wire [7:0] data_in,
    input wire [7:0] data_out,
    input wire data_oe_n,
    input wire [CHANNELS-1:0] counter_clk,
    input wire [CHANNELS-1:0] gate,
    input wire [CHANNELS-1:0] out_level,
    input wire [CHANNELS-1:0] count_load,
    input wire [CHANNELS*`CW_KEPT_WIDTH-1:0] mode_word,
    input wire [CHANNELS*COUNT_WIDTH-1:0] down_count
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire rd_req = !cs_n && !rd_n && wr_n;
    wire wr3 = !cs_n && !wr_n && port_sel_hi && port_sel_lo;
    wire sel3 = port_sel_hi && port_sel_lo;
    reg [3:0] ck0_q;
    // ==========================================
    // Counter 0 clock history
    // A fall in the last few samples is the only excuse for a count change
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ck0_q <= 4'h0;
        end else begin
            ck0_q <= {ck0_q[2:0], counter_clk[0]};
        end
    end
    wire ck0_fell = |(ck0_q[3:1] & ~ck0_q[2:0]);
    sequence s_rd_start;
        $rose(rd_req);
    endsequence
    sequence s_rd_end;
        rd_req ##1 !rd_req;
    endsequence
    property p_idle;
        cs_n ##1 cs_n |-> data_oe_n;
    endproperty
    property p_port3;
        sel3 && wr_n ##1 sel3 && wr_n |-> data_oe_n;
    endproperty
    property p_rd_lat;
        s_rd_start and !sel3 |-> ##[1:2] !data_oe_n;
    endproperty
    property p_rd_end;
        s_rd_end |-> ##[1:2] data_oe_n;
    endproperty
    property p_mode;
        $rose(wr3) && data_in[7:6] == 2'h0 && data_in[5:4] != 2'h0
            |=> mode_word[5:0] == $past(data_in[5:0]);
    endproperty
    property p_mode_hold;
        $changed(mode_word) |-> $past(wr3);
    endproperty
    property p_cnt_stable;
        $changed(down_count[15:0]) |-> ck0_fell;
    endproperty
    property p_load_pulse;
        count_load[0] |=> !count_load[0];
    endproperty
    property p_load_cause;
        count_load[0] |-> ck0_fell;
    endproperty
    a_idle: assert property (p_idle) else $error("bus driven while idle");
    a_port3: assert property (p_port3) else $error("mode port drove bus");
    a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
    a_rd_end: assert property (p_rd_end) else $error("bus not released");
    a_mode: assert property (p_mode) else $error("mode bits not kept");
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
    a_cnt_stable: assert property (p_cnt_stable) else $error("count moved");
    a_load_pulse: assert property (p_load_pulse) else $error("load long");
    a_load_cause: assert property (p_load_cause) else $error("stray load");
endmodule
bind interval_timer timer_properties #(
    .CHANNELS(CHANNELS),
    .COUNT_WIDTH(COUNT_WIDTH)
) u_props (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .port_sel_hi(port_sel_hi), .port_sel_lo(port_sel_lo),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .counter_clk(counter_clk), .gate(gate), .out_level(out_level),
    .count_load(count_load), .mode_word(mode_word),
    .down_count(down_count));
`default_nettype wire

/* tb/timer_host_program_readback_test.sv */
// Self-checking bench for interval timer programming and readback
`timescale 1ns/1ns
`default_nettype none
module timer_host_program_readback_test;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] counter_clk = 3'h0;
    logic [2:0] gate = 3'h0;
    logic [2:0] out_level = 3'h0;
    wire cs_n, rd_n, wr_n, port_sel_hi, port_sel_lo, data_oe_n;
    wire [7:0] data_in, data_out;
    wire [2:0] count_load;
    wire [17:0] mode_word;
    wire [47:0] down_count;
    integer fails = 0;
    integer compares = 0;
    integer cycles = 0;
    integer i, k;
    logic [15:0] n [0:2];
    logic [15:0] v;
    logic [7:0] b;
    logic [31:0] r;
    always #5 clock = ~clock;
    interval_timer u_dut (.clock(clock), .rst_n(rst_n), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .port_sel_hi(port_sel_hi),
        .port_sel_lo(port_sel_lo), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .counter_clk(counter_clk), .gate(gate),
        .out_level(out_level), .count_load(count_load),
        .mode_word(mode_word), .down_count(down_count));
    host_bus_model u_host (.clock(clock), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .port_sel_hi(port_sel_hi), .port_sel_lo(port_sel_lo),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
    // ==========================================
    // Checking and closing
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Expected state byte: pin level, pending load, kept mode bits
    function [15:0] sts(input logic ol, input logic nul);
        sts = {8'h00, ol, nul, 6'h30};
    endfunction
    // Counter clocks stand still between pulses
    task pulse(input logic [2:0] m);
        @(negedge clock);
        counter_clk = m;
        repeat (2) @(negedge clock);
        counter_clk = 3'h0;
        repeat (2) @(negedge clock);
    endtask
    task rd16(input logic [1:0] p, output logic [15:0] d);
        u_host.rd(p, d[7:0]);
        u_host.rd(p, d[15:8]);
    endtask
    // Hang guard: the whole run needs a few hundred cycles
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            end_sim;
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        r = $urandom(93641);
        repeat (20) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        // Program counters 2, 0, 1; status before any load
        for (i = 2; i < 5; i = i + 1) begin
            k = i % 3;
            r = $urandom;
            n[k] = r[15:0];
            out_level = r[18:16];
            u_host.wr(2'h3, {k[1:0], 6'h30});
            u_host.wr(k[1:0], n[k][7:0]);
            u_host.wr(k[1:0], n[k][15:8]);
            u_host.wr(2'h3, 8'hE0 | (8'h02 << k));
            u_host.rd(k[1:0], b);
            chk({8'h00, b}, sts(out_level[k], 1'b1));
            chk({10'h000, mode_word[6*k +: 6]}, 16'h0030);
        end
        // Load, count, latch twice, then read each counter
        gate = 3'h7;
        pulse(3'h7);
        r = $urandom;
        k = 1 + r[1:0];
        repeat (k) pulse(3'h7);
        u_host.wr(2'h3, 8'hCE);
        repeat (2) pulse(3'h7);
        u_host.wr(2'h3, 8'hCE);
        u_host.wr(2'h3, 8'h00);
        for (i = 0; i < 3; i = i + 1) begin
            u_host.rd(i[1:0], b);
            chk({8'h00, b}, sts(out_level[i], 1'b0));
            rd16(i[1:0], v);
            chk(v, n[i] - k[15:0]);
        end
        // Interleaved reads and writes on counter 0
        gate = 3'h0;
        r = $urandom;
        u_host.wr(2'h3, 8'h00);
        u_host.rd(2'h0, v[7:0]);
        u_host.wr(2'h0, r[7:0]);
        u_host.rd(2'h0, v[15:8]);
        u_host.wr(2'h0, r[15:8]);
        chk(v, n[0] - k[15:0] - 16'h0002);
        pulse(3'h1);
        rd16(2'h0, v);
        chk(v, r[15:0]);
        // Low-only BCD on counter 2, high-only on counter 1
        u_host.wr(2'h3, 8'h91);
        u_host.wr(2'h2, 8'h00);
        u_host.wr(2'h3, 8'h60);
        u_host.wr(2'h1, r[23:16]);
        pulse(3'h6);
        gate = 3'h4;
        pulse(3'h4);
        chk(down_count[47:32], 16'h9999);
        chk(down_count[31:16], {r[23:16], 8'h00});
        u_host.rd(2'h2, b);
        chk({8'h00, b}, 16'h0099);
        u_host.rd(2'h1, b);
        chk({8'h00, b}, {8'h00, r[23:16]});
        u_host.rd(2'h3, b);
        end_sim;
    end
endmodule
`default_nettype wire
